// File: hw/unvm_read_port.sv
// User nonvolatile store with a fabric byte read port and a programming port.
// Assumes the programming path (already decrypted where chosen) sits on the same clock.
//
// How it works
// R1: The store keeps 1024 bits of user data, held across power loss.
// R2: For programming the store is eight banks of 128 bits each.
// R3: Fabric reads return one byte per access on the fabric clock.
// R4: Only the 7-bit fabric address selects which byte of which bank returns.
// R5: Address bits six to four select one of eight banks.
// R6: Address bits three to zero select one of sixteen bytes in the bank.
// R7: Erase and write come only from the programming path, never the fabric.
// R8: Contents read back both over the programming path and fabric addressing.
// R9: Incoming programming data may be passed through decryption before writing.
// R10: The address is sampled on a clock edge; data appears by the next edge.
`timescale 1ns/10ps
module unvm_read_port
  import unvm_pkg::*;
(
  // Clock, reset and enable.
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Fabric read port.
  input wire unvm_pkg::unvm_addr_t i_rd_addr,
  output logic [unvm_pkg::UNVM_DATA_W-1:0] o_rd_data,
  // Programming path.
  input wire logic i_prog_erase,
  input wire logic [2:0] i_prog_bank,
  input wire logic i_prog_wr,
  input wire unvm_pkg::unvm_addr_t i_prog_addr,
  input wire logic [unvm_pkg::UNVM_DATA_W-1:0] i_prog_data,
  input wire logic i_prog_decrypt,
  input wire logic [unvm_pkg::UNVM_DATA_W-1:0] i_prog_dec_data,
  output logic [unvm_pkg::UNVM_DATA_W-1:0] o_prog_rd_data,
  output logic o_prog_busy
);
  import unvm_pkg::*;

  typedef struct packed {
    unvm_prog_e prog;
    logic [2:0] bank;
    logic [3:0] cnt;
    unvm_byte_t rd_data;
    unvm_byte_t prog_rd;
  } unvm_state_s;

  // State register and its next value.
  unvm_state_s st_reg;
  unvm_state_s st_next;

  // Store array, one byte per entry.
  unvm_byte_t mem [UNVM_WORDS];

  // Bank and byte fields of the two read addresses.
  logic [2:0] rd_bank;
  logic [3:0] rd_byte;
  logic [2:0] pr_bank;
  logic [3:0] pr_byte;

  // Per-bank candidates for the addressed byte.
  logic [UNVM_BANKS-1:0] rd_bank_hit;
  logic [UNVM_BANKS-1:0] pr_bank_hit;
  unvm_byte_t rd_bank_byte [UNVM_BANKS];
  unvm_byte_t pr_bank_byte [UNVM_BANKS];
  unvm_byte_t rd_sel;
  unvm_byte_t pr_sel;

  // Programming requests and erase sequencing.
  logic idle;
  logic erase_go;
  logic write_go;
  logic erase_last;
  logic [3:0] erase_cnt_next;
  unvm_addr_t erase_addr;

  // Write port of the array.
  unvm_byte_t wr_byte;
  unvm_byte_t wr_value;
  logic wr_en;
  unvm_addr_t wr_addr;

  // Split each address into its bank and byte fields.
  assign rd_bank = i_rd_addr[UNVM_BANK_MSB:UNVM_BANK_LSB]; // R5
  assign rd_byte = i_rd_addr[UNVM_BYTE_MSB:UNVM_BYTE_LSB]; // R6
  assign pr_bank = i_prog_addr[UNVM_BANK_MSB:UNVM_BANK_LSB];
  assign pr_byte = i_prog_addr[UNVM_BYTE_MSB:UNVM_BYTE_LSB];

  // Each bank offers the byte that the byte field picks inside it.
  for (genvar g = 0; g < UNVM_BANKS; g++) begin : g_bank
    assign rd_bank_hit[g] = (rd_bank == 3'(g)); // R5
    assign pr_bank_hit[g] = (pr_bank == 3'(g));
    assign rd_bank_byte[g] = mem[{3'(g), rd_byte}]; // R6
    assign pr_bank_byte[g] = mem[{3'(g), pr_byte}];
  end : g_bank

  // The fabric port keeps the byte of the bank that its bank field selects.
  always_comb begin
    rd_sel = UNVM_RESET_DOUT;
    for (int b = 0; b < UNVM_BANKS; b++) begin
      if (rd_bank_hit[b]) begin
        rd_sel = rd_bank_byte[b]; // R4
      end
    end
  end

  // The programming read-back picks its byte the same way.
  always_comb begin
    pr_sel = UNVM_RESET_DOUT;
    for (int b = 0; b < UNVM_BANKS; b++) begin
      if (pr_bank_hit[b]) begin
        pr_sel = pr_bank_byte[b]; // R8
      end
    end
  end

  // Requests are taken only while no erase runs; erase wins over write.
  always_comb begin
    idle = 1'h0;
    erase_go = 1'h0;
    write_go = 1'h0;
    if (st_reg.prog == UNVM_PROG_IDLE) begin
      idle = 1'h1;
      if (i_prog_erase) begin
        erase_go = 1'h1;
      end else if (i_prog_wr) begin
        write_go = 1'h1; // R7
      end
    end
  end

  // Erase walks the sixteen bytes of the chosen bank in order.
  assign erase_last = (st_reg.cnt == UNVM_ERASE_LAST);
  assign erase_cnt_next = st_reg.cnt + 4'h1;
  assign erase_addr = {st_reg.bank, st_reg.cnt}; // R2

  // Write data comes from the decryption engine when that is asked for.
  always_comb begin
    if (i_prog_decrypt) begin
      wr_byte = i_prog_dec_data; // R9
    end else begin
      wr_byte = i_prog_data;
    end
  end

  // Next state: read captures and the erase sequencer.
  always_comb begin
    st_next = st_reg;
    st_next.rd_data = rd_sel; // R3 R10
    st_next.prog_rd = pr_sel; // R8
    case (st_reg.prog)
      UNVM_PROG_IDLE: begin
        if (erase_go) begin
          st_next.prog = UNVM_PROG_ERASE;
          st_next.bank = i_prog_bank; // R2
          st_next.cnt = UNVM_ERASE_FIRST;
        end
      end
      UNVM_PROG_ERASE: begin
        st_next.cnt = erase_cnt_next;
        if (erase_last) begin
          st_next.prog = UNVM_PROG_IDLE;
          st_next.cnt = UNVM_RESET_CNT;
        end
      end
      UNVM_PROG_WRITE: begin
        st_next.prog = UNVM_PROG_IDLE;
      end
      default: begin
        st_next.prog = UNVM_PROG_IDLE;
      end
    endcase
  end

  // Write port: one programmed byte, or the erased value while a bank is wiped.
  always_comb begin
    wr_en = 1'h0;
    wr_addr = i_prog_addr;
    wr_value = wr_byte;
    case (st_reg.prog)
      UNVM_PROG_IDLE: begin
        if (write_go) begin
          wr_en = 1'h1; // R7
        end
      end
      UNVM_PROG_ERASE: begin
        wr_en = 1'h1;
        wr_addr = erase_addr; // R2
        wr_value = UNVM_ERASED_BYTE;
      end
      default: begin
        wr_en = 1'h0;
      end
    endcase
  end

  // State register; the clock enable freezes every field.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg.prog <= UNVM_PROG_IDLE;
      st_reg.bank <= UNVM_RESET_BANK;
      st_reg.cnt <= UNVM_RESET_CNT;
      st_reg.rd_data <= UNVM_RESET_DOUT; // R3
      st_reg.prog_rd <= UNVM_RESET_DOUT;
    end else if (i_ce) begin
      st_reg <= st_next; // R3 R10
    end
  end

  // The array is not reset so its contents survive a logic reset.
  always_ff @(posedge i_core_clk) begin
    if (i_ce && wr_en) begin
      mem[wr_addr] <= wr_value; // R1 R7
    end
  end

  // Read data comes straight from the state register.
  assign o_rd_data = st_reg.rd_data; // R5 R6
  assign o_prog_rd_data = st_reg.prog_rd; // R8

  // Busy is a handshake output taken from the state.
  assign o_prog_busy = !idle;
endmodule : unvm_read_port

// File: hw/unvm_pkg.sv
// Package for the user nonvolatile store byte read port.
// Assumes a single fabric clock domain and no software-visible registers.
package unvm_pkg;
  localparam int unsigned UNVM_BANKS = 8;
  localparam int unsigned UNVM_BANK_BITS = 128;
  localparam int unsigned UNVM_BYTES_PER_BANK = 16;
  localparam int unsigned UNVM_TOTAL_BITS = 1024;
  localparam int unsigned UNVM_ADDR_W = 7;
  localparam int unsigned UNVM_BANK_MSB = 6;
  localparam int unsigned UNVM_BANK_LSB = 4;
  localparam int unsigned UNVM_BYTE_MSB = 3;
  localparam int unsigned UNVM_BYTE_LSB = 0;
  localparam int unsigned UNVM_DATA_W = 8;
  localparam int unsigned UNVM_WORDS = 128;
  localparam logic [7:0] UNVM_ERASED_BYTE = 8'hff;
  localparam logic [7:0] UNVM_RESET_DOUT = 8'h00;
  localparam logic [2:0] UNVM_RESET_BANK = 3'h0;
  localparam logic [3:0] UNVM_RESET_CNT = 4'h0;
  localparam logic [3:0] UNVM_ERASE_FIRST = 4'h0;
  localparam logic [3:0] UNVM_ERASE_LAST = 4'hf;

  typedef logic [UNVM_ADDR_W-1:0] unvm_addr_t;
  typedef logic [UNVM_DATA_W-1:0] unvm_byte_t;

  typedef enum logic [2:0] {
    UNVM_PROG_IDLE = 3'b001,
    UNVM_PROG_ERASE = 3'b010,
    UNVM_PROG_WRITE = 3'b100
  } unvm_prog_e;
endpackage : unvm_pkg

// File: dv/unvm_chk.sv
// Checker for the store port, watching only its top-level ports.
// Assumes one fabric clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module unvm_chk
  import unvm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [6:0] i_rd_addr,
  input wire logic [7:0] o_rd_data,
  input wire logic i_prog_erase,
  input wire logic [2:0] i_prog_bank,
  input wire logic i_prog_wr,
  input wire logic [6:0] i_prog_addr,
  input wire logic [7:0] i_prog_data,
  input wire logic i_prog_decrypt,
  input wire logic [7:0] i_prog_dec_data,
  input wire logic [7:0] o_prog_rd_data,
  input wire logic o_prog_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_quiet;
    i_ce && !o_prog_busy && !i_prog_wr && !i_prog_erase;
  endsequence
  sequence s_write_taken;
    i_ce && !o_prog_busy && !i_prog_erase && i_prog_wr;
  endsequence
  sequence s_hold_addr;
    i_ce && $stable(i_prog_addr);
  endsequence
  sequence s_busy_run;
    o_prog_busy[*8] ##1 o_prog_busy[*8];
  endsequence
  sequence s_same_read;
    s_quiet ##1 (s_quiet && $stable(i_rd_addr) && (i_rd_addr == i_prog_addr));
  endsequence
  chk_reset_quiet: assert property ($rose(i_rstn) |-> !o_prog_busy && (o_rd_data == UNVM_RESET_DOUT))
    else $error("outputs not at reset values after reset release");
  chk_ce_freeze: assert property (!i_ce |=> $stable(o_rd_data) && $stable(o_prog_rd_data) && $stable(o_prog_busy))
    else $error("outputs moved while clock enable was low");
  chk_busy_start: assert property ((i_ce && !o_prog_busy && i_prog_erase) |=> o_prog_busy)
    else $error("erase request did not raise busy");
  chk_busy_span: assert property (disable iff (!i_rstn || !i_ce) $rose(o_prog_busy) |-> s_busy_run ##1 !o_prog_busy)
    else $error("busy span is not sixteen cycles");
  chk_wr_readback: assert property (s_write_taken ##1 s_hold_addr |=> o_prog_rd_data == ($past(i_prog_decrypt, 2) ? $past(i_prog_dec_data, 2) : $past(i_prog_data, 2)))
    else $error("written byte not read back");
  chk_port_agree: assert property ((s_quiet && (i_rd_addr == i_prog_addr)) |=> o_rd_data == o_prog_rd_data)
    else $error("fabric and programming read-back disagree");
  chk_fab_read_only: assert property (s_same_read |=> $stable(o_rd_data))
    else $error("store byte changed without programming");
endmodule : unvm_chk
bind unvm_read_port unvm_chk u_chk (
  .i_core_clk(i_core_clk),
  .i_rstn(i_rstn),
  .i_ce(i_ce),
  .i_rd_addr(i_rd_addr),
  .o_rd_data(o_rd_data),
  .i_prog_erase(i_prog_erase),
  .i_prog_bank(i_prog_bank),
  .i_prog_wr(i_prog_wr),
  .i_prog_addr(i_prog_addr),
  .i_prog_data(i_prog_data),
  .i_prog_decrypt(i_prog_decrypt),
  .i_prog_dec_data(i_prog_dec_data),
  .o_prog_rd_data(o_prog_rd_data),
  .o_prog_busy(o_prog_busy)
);

// File: dv/unvm_fab_mdl.sv
// Fabric reader model.
// Assumes the port answers on the same edge at which it samples the address, one clock after the model drives it.
`timescale 1ns/10ps
module unvm_fab_mdl(input wire logic i_core_clk, input wire logic [7:0] i_rd_data,
  output logic [6:0] o_rd_addr = 7'h00);
  task rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge i_core_clk) o_rd_addr <= a;
    @(posedge i_core_clk) #1 d = i_rd_data;
  endtask : rd
endmodule : unvm_fab_mdl

// File: dv/tb_user_nvm_byte_read_port.sv
// Store port bench.
`timescale 1ns/10ps
module tb_user_nvm_byte_read_port;
  logic c = 0, n = 0, e = 0, w = 0, k = 0, ce = 1, b;
  logic [2:0] bk = 3'h5;
  logic [6:0] a = 7'h7f, r;
  logic [7:0] p = 8'h3c, q = 8'hc3, d, s, v, hd, hs;
  int failures, checked;
  always #4 c = ~c;
  unvm_fab_mdl u_fab(.i_core_clk(c), .i_rd_data(d), .o_rd_addr(r));
  unvm_read_port u_dut(.i_core_clk(c), .i_rstn(n), .i_ce(ce), .i_rd_addr(r), .o_rd_data(d), .i_prog_erase(e),
    .i_prog_bank(bk), .i_prog_wr(w), .i_prog_addr(a), .i_prog_data(p), .i_prog_decrypt(k), .i_prog_dec_data(q),
    .o_prog_rd_data(s), .o_prog_busy(b));
  task cmp(input logic [7:0] x, y);
    checked++;
    if (x !== y) begin failures++; $display("Error %0t: seen %h expected %h", $time, x, y); end
  endtask : cmp
  task finish_test;
    $display("errs %0d of %0d", failures, checked);
    if (!failures && checked)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  task t_write(input logic [6:0] x, logic y);
    @(posedge c) begin w <= 1; k <= y; a <= x; end
    @(posedge c) w <= 0;
    @(posedge c) #1 cmp(s, y ? q : p);
  endtask : t_write
  task t_erase(input logic [2:0] g);
    @(posedge c) begin e <= 1; bk <= g; end
    @(posedge c) begin e <= 0; w <= 1; k <= 1; a <= 7'h4f; end
    #1 cmp({7'h00, b}, 8'h01);
    @(posedge c) w <= 0;
    repeat (14) @(posedge c);
    #1 cmp({7'h00, b}, 8'h01);
    @(posedge c) #1 cmp({7'h00, b}, 8'h00);
    for (int i = 79; i < 97; i++) begin u_fab.rd(i[6:0], v); cmp(v, i == 79 ? p : i == 96 ? q : 8'hff); end
  endtask : t_erase
  task t_ce;
    @(posedge c) begin ce <= 0; w <= 1; k <= 0; a <= 7'h60; end
    #1 begin hd = d; hs = s; end
    @(posedge c);
    @(posedge c) begin ce <= 1; w <= 0; end
    #1 cmp(d, hd);
    cmp(s, hs);
    u_fab.rd(7'h60, v);
    cmp(v, q);
  endtask : t_ce
  task t_reset;
    @(posedge c) n <= 0;
    #1 cmp(d, 8'h00);
    cmp(s, 8'h00);
    cmp({7'h00, b}, 8'h00);
    @(posedge c) n <= 1;
    u_fab.rd(7'h4f, v);
    cmp(v, p);
  endtask : t_reset
  initial begin
    repeat (10) @(posedge c);
    n <= 1;
    t_write(7'h4f, 0);
    t_write(7'h60, 1);
    t_erase(3'h5);
    t_ce;
    t_reset;
    finish_test;
  end
  initial begin #4000 failures++; finish_test; end
endmodule : tb_user_nvm_byte_read_port
